/* usb_sie_pkg.sv */
// Shared constants, field layout and carrier types of the USB engine control registers
`default_nettype none

package usb_sie_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address on the bus is four times the index
    localparam int unsigned IDX_W = 8;
    localparam logic [7:0] IDX_CLOCK_CTRL = 8'h22;
    localparam logic [7:0] IDX_ADDR_WAKE = 8'h23;
    localparam logic [7:0] IDX_HALT = 8'h24;
    localparam logic [7:0] IDX_ENGINE_STATUS = 8'h25;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h31;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock control register fields
    localparam int unsigned SEL_LSB = 0;
    localparam int unsigned SEL_W = 3;
    localparam int unsigned BIT_USB_CLK = 3;
    localparam int unsigned BIT_DEEP_SUSP = 4;
    localparam int unsigned BIT_PLL_SEL = 5;
    localparam int unsigned BIT_XTAL_SEL = 6;
    localparam logic [2:0] SEL_LAST_EP = 3'h4;

    // Address and wake register fields
    localparam int unsigned BIT_WAKE = 0;
    localparam int unsigned ADDR_LSB = 1;
    localparam int unsigned ADDR_W = 7;

    // Engine status register fields
    localparam int unsigned BIT_DEFER = 0;
    localparam int unsigned BIT_EP0_ERR = 1;
    localparam int unsigned BIT_OUT_TOK = 2;
    localparam int unsigned BIT_IN_TOK = 3;

    // Interrupt status and mask fields
    localparam int unsigned IRQ_SETUP = 0;
    localparam int unsigned IRQ_EP0_ERR = 1;
    localparam int unsigned IRQ_OUT_TOK = 2;
    localparam int unsigned IRQ_IN_DONE = 3;
    localparam int unsigned IRQ_USB_RST = 4;
    localparam int unsigned IRQ_W = 5;

    ////////////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [6:0] RST_CLOCK_CTRL = 7'h00;
    localparam logic [7:0] RST_ADDR_WAKE = 8'h00;
    localparam logic [4:0] RST_HALT = 5'h00;
    localparam logic [4:0] RST_IRQ = 5'h00;
    localparam logic [6:0] RST_ACTIVE_ADDR = 7'h00;

    // Transfer kind served by each endpoint
    typedef enum logic [1:0] {
        EP_CONTROL = 2'h0,
        EP_INTERRUPT = 2'h1,
        EP_ISO_OUT = 2'h2,
        EP_ISO_IN = 2'h3
    } ep_kind_t;

    // Events from the serial engine, all on the system clock
    typedef struct packed {
        logic usb_reset;
        logic setup_token;
        logic in_done;
        logic ep0_err;
        logic out_token;
        logic in_token;
    } sie_evt_t;

endpackage

`default_nettype wire

/* usb_sie_ctrl_status_regs.sv */
// Control and status registers of the USB serial interface engine, Wishbone slave
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

module usb_sie_ctrl_status_regs #(
    parameter int unsigned NUM_EP = 5
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire usb_sie_pkg::sie_evt_t sie_evt_i,
    input wire logic fifo_rd_req_i,
    input wire logic fifo_wr_req_i,
    output logic [2:0] fifo_selector_o,
    output logic sel_valid_o,
    output usb_sie_pkg::ep_kind_t sel_ep_kind_o,
    output logic [NUM_EP-1:0] fifo_rd_o,
    output logic [NUM_EP-1:0] fifo_wr_o,
    output logic usb_clock_gate_o,
    output logic deep_suspend_ctl_o,
    output logic pll_clock_sel_o,
    output logic crystal_freq_sel_o,
    output logic remote_wake_allow_o,
    output logic [6:0] dev_addr_o,
    output logic [4:0] endpoint_halt_bits_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic ack_q;
    logic [7:0] rdat_d;
    logic [31:0] rdat_q;
    logic [7:0] idx;
    logic bus_req;
    logic wr_en;
    logic [7:0] wdat;
    logic [6:0] clock_ctrl_reg_q;
    logic [7:0] addr_wake_reg_q;
    logic [4:0] halt_q;
    logic defer_q;
    logic err_q;
    logic out_q;
    logic in_q;
    logic pending_q;
    logic [6:0] active_addr_q;
    logic [4:0] irq_stat_q;
    logic [4:0] irq_mask_q;
    logic [4:0] irq_evt;
    logic [2:0] fifo_selector;
    logic wr_clock;
    logic wr_addr;
    logic wr_halt;
    logic wr_status;
    logic wr_irq_stat;
    logic wr_irq_mask;

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone classic slave: ack one cycle after the strobe, writes land on the ack edge
    assign idx = wb_adr_i[9:2];
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign wr_en = bus_req & wb_we_i & ack_q & wb_sel_i[0];
    assign wdat = wb_dat_i[7:0];

    // Per-register write strobes
    assign wr_clock = wr_en && (idx == usb_sie_pkg::IDX_CLOCK_CTRL);
    assign wr_addr = wr_en && (idx == usb_sie_pkg::IDX_ADDR_WAKE);
    assign wr_halt = wr_en && (idx == usb_sie_pkg::IDX_HALT);
    assign wr_status = wr_en && (idx == usb_sie_pkg::IDX_ENGINE_STATUS);
    assign wr_irq_stat = wr_en && (idx == usb_sie_pkg::IDX_IRQ_STATUS);
    assign wr_irq_mask = wr_en && (idx == usb_sie_pkg::IDX_IRQ_MASK);

    // Ack drops after one cycle so back-to-back requests see a fresh handshake
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req & ~ack_q;
        end
    end

    // Read multiplexer; unmapped indices answer with zero rather than an error
    always_comb begin
        rdat_d = 8'h00;
        if (idx == usb_sie_pkg::IDX_CLOCK_CTRL) begin
            rdat_d = {1'b0, clock_ctrl_reg_q};
        end else if (idx == usb_sie_pkg::IDX_ADDR_WAKE) begin
            rdat_d = addr_wake_reg_q;
        end else if (idx == usb_sie_pkg::IDX_HALT) begin
            rdat_d = {3'h0, halt_q};
        end else if (idx == usb_sie_pkg::IDX_ENGINE_STATUS) begin
            rdat_d = {4'h0, in_q, out_q, err_q, defer_q};
        end else if (idx == usb_sie_pkg::IDX_IRQ_STATUS) begin
            rdat_d = {3'h0, irq_stat_q};
        end else if (idx == usb_sie_pkg::IDX_IRQ_MASK) begin
            rdat_d = {3'h0, irq_mask_q};
        end
    end

    // Read data is captured as the ack is raised
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdat_q <= 32'h0000_0000;
        end else if (bus_req & ~ack_q) begin
            rdat_q <= {24'h00_0000, rdat_d};
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock control register: selector, USB clock gate, suspend, clock sources
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clock_ctrl_reg_q <= usb_sie_pkg::RST_CLOCK_CTRL;
        end else if (wr_clock) begin
            clock_ctrl_reg_q <= wdat[6:0];
        end
    end

    assign fifo_selector = clock_ctrl_reg_q[usb_sie_pkg::SEL_LSB +: usb_sie_pkg::SEL_W];
    assign fifo_selector_o = fifo_selector;
    assign usb_clock_gate_o = clock_ctrl_reg_q[usb_sie_pkg::BIT_USB_CLK];
    // Only stored here; firmware owns the timing of the deep suspend setting
    assign deep_suspend_ctl_o = clock_ctrl_reg_q[usb_sie_pkg::BIT_DEEP_SUSP];
    assign pll_clock_sel_o = clock_ctrl_reg_q[usb_sie_pkg::BIT_PLL_SEL];
    assign crystal_freq_sel_o = clock_ctrl_reg_q[usb_sie_pkg::BIT_XTAL_SEL];

    ////////////////////////////////////////////////////////////////////////////////
    // Endpoint selection and FIFO strobes; reserved codes match no endpoint
    assign sel_valid_o = (fifo_selector <= usb_sie_pkg::SEL_LAST_EP);

    // Transfer kind of the selected endpoint
    always_comb begin
        case (fifo_selector)
            3'h0: sel_ep_kind_o = usb_sie_pkg::EP_CONTROL;
            3'h1: sel_ep_kind_o = usb_sie_pkg::EP_INTERRUPT;
            3'h2: sel_ep_kind_o = usb_sie_pkg::EP_ISO_OUT;
            3'h3: sel_ep_kind_o = usb_sie_pkg::EP_ISO_IN;
            3'h4: sel_ep_kind_o = usb_sie_pkg::EP_INTERRUPT;
            default: sel_ep_kind_o = usb_sie_pkg::EP_CONTROL;
        endcase
    end

    // One strobe per endpoint; a reserved code decodes to none of them
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++) begin : gen_fifo_strobe
            assign fifo_rd_o[g] = fifo_rd_req_i && (fifo_selector == 3'(g));
            assign fifo_wr_o[g] = fifo_wr_req_i && (fifo_selector == 3'(g));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Address and wake register
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            addr_wake_reg_q <= usb_sie_pkg::RST_ADDR_WAKE;
        end else if (wr_addr) begin
            addr_wake_reg_q <= wdat;
        end
    end

    assign remote_wake_allow_o = addr_wake_reg_q[usb_sie_pkg::BIT_WAKE];

    // Address the engine answers to; a write made while deferred is adopted only on the next IN completion
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            active_addr_q <= usb_sie_pkg::RST_ACTIVE_ADDR;
        end else if (wr_addr && !defer_q) begin
            active_addr_q <= wdat[usb_sie_pkg::ADDR_LSB +: usb_sie_pkg::ADDR_W];
        end else if (defer_q && pending_q && sie_evt_i.in_done) begin
            active_addr_q <= addr_wake_reg_q[usb_sie_pkg::ADDR_LSB +: usb_sie_pkg::ADDR_W];
        end
    end

    // A deferred write waits here until the host has read back the status stage
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pending_q <= 1'b0;
        end else if (wr_addr) begin
            pending_q <= defer_q;
        end else if (sie_evt_i.in_done || !defer_q) begin
            pending_q <= 1'b0;
        end
    end

    assign dev_addr_o = active_addr_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Endpoint halt bits; the bus events win over a coincident firmware write
    generate
        for (g = 0; g < 5; g++) begin : gen_halt
            always_ff @(posedge clock_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    halt_q[g] <= usb_sie_pkg::RST_HALT[g];
                end else if (sie_evt_i.usb_reset || sie_evt_i.setup_token) begin
                    halt_q[g] <= 1'b0;
                end else if (wr_halt) begin
                    halt_q[g] <= wdat[g];
                end
            end
        end
    endgenerate

    assign endpoint_halt_bits_o = halt_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Engine status: deferred flag is plain storage, firmware clears it itself
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            defer_q <= 1'b0;
        end else if (wr_status) begin
            defer_q <= wdat[usb_sie_pkg::BIT_DEFER];
        end
    end

    // Error flag: a new error beats a firmware clear in the same cycle
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            err_q <= 1'b0;
        end else if (sie_evt_i.ep0_err) begin
            err_q <= 1'b1;
        end else if (wr_status) begin
            err_q <= wdat[usb_sie_pkg::BIT_EP0_ERR];
        end
    end

    // OUT flag: set wins over both the firmware write and the SETUP clear
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_q <= 1'b0;
        end else if (sie_evt_i.out_token) begin
            out_q <= 1'b1;
        end else if (wr_status) begin
            out_q <= wdat[usb_sie_pkg::BIT_OUT_TOK];
        end else if (sie_evt_i.setup_token) begin
            out_q <= 1'b0;
        end
    end

    // IN indication follows the engine one cycle late; writes cannot touch it
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            in_q <= 1'b0;
        end else begin
            in_q <= sie_evt_i.in_token;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupts: sticky events, write one to clear, set wins over clear
    assign irq_evt[usb_sie_pkg::IRQ_SETUP] = sie_evt_i.setup_token;
    assign irq_evt[usb_sie_pkg::IRQ_EP0_ERR] = sie_evt_i.ep0_err;
    assign irq_evt[usb_sie_pkg::IRQ_OUT_TOK] = sie_evt_i.out_token;
    assign irq_evt[usb_sie_pkg::IRQ_IN_DONE] = sie_evt_i.in_done;
    assign irq_evt[usb_sie_pkg::IRQ_USB_RST] = sie_evt_i.usb_reset;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_stat_q <= usb_sie_pkg::RST_IRQ;
        end else if (wr_irq_stat) begin
            irq_stat_q <= (irq_stat_q & ~wdat[4:0]) | irq_evt;
        end else begin
            irq_stat_q <= irq_stat_q | irq_evt;
        end
    end

    // Mask: a one lets the matching status bit reach the interrupt line
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_mask_q <= usb_sie_pkg::RST_IRQ;
        end else if (wr_irq_mask) begin
            irq_mask_q <= wdat[4:0];
        end
    end

    assign irq_o = |(irq_stat_q & irq_mask_q);

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    chk_reserved_no_access: assert property (
        (fifo_selector > usb_sie_pkg::SEL_LAST_EP) |-> (fifo_rd_o == '0 && fifo_wr_o == '0))
        else $error("FIFO strobe under reserved selector");

    chk_selector_strobe_map: assert property (
        (fifo_rd_req_i && fifo_selector == 3'h2) |-> (fifo_rd_o == 5'h04))
        else $error("Selector two did not strobe endpoint two");

    chk_clock_gate_write: assert property (
        wr_clock |=> (usb_clock_gate_o == $past(wdat[3])) && (pll_clock_sel_o == $past(wdat[5])))
        else $error("Clock control write not reflected");

    chk_immediate_addr: assert property (
        (wr_addr && !defer_q) |=> (dev_addr_o == $past(wdat[7:1])))
        else $error("Address not adopted at once");

    chk_deferred_hold: assert property (
        (wr_addr && defer_q) ##1 (!sie_evt_i.in_done && defer_q) |=> $stable(dev_addr_o))
        else $error("Deferred address adopted before IN completion");

    chk_deferred_adopt: assert property (
        (defer_q && pending_q && sie_evt_i.in_done && !wr_addr)
        |=> (dev_addr_o == $past(addr_wake_reg_q[7:1])))
        else $error("Deferred address not adopted after IN");

    chk_halt_cleared: assert property (
        (sie_evt_i.usb_reset || sie_evt_i.setup_token) |=> (endpoint_halt_bits_o == 5'h00))
        else $error("Halt bits survived reset or SETUP");

    chk_halt_upper_zero: assert property (
        (bus_req && !ack_q && idx == usb_sie_pkg::IDX_HALT) |=> (wb_dat_o[7:5] == 3'h0))
        else $error("Halt upper bits read nonzero");

    chk_err_set_wins: assert property (
        sie_evt_i.ep0_err |=> err_q)
        else $error("Endpoint zero error lost");

    chk_out_flag: assert property (
        (sie_evt_i.setup_token && !sie_evt_i.out_token && !wr_status) |=> !out_q)
        else $error("OUT flag not cleared by SETUP");

    chk_in_follows: assert property (
        ##1 (in_q == $past(sie_evt_i.in_token)))
        else $error("IN indication does not track token");

    chk_ep_kinds: assert property (
        (fifo_selector == 3'h3) |-> (sel_ep_kind_o == usb_sie_pkg::EP_ISO_IN))
        else $error("Endpoint three kind wrong");

    chk_irq_level: assert property (
        (irq_stat_q & irq_mask_q) == 5'h00 |-> !irq_o)
        else $error("Interrupt high with nothing pending");

    // A firmware clear in the same cycle must not swallow a new event
    chk_irq_sticky_set: assert property (
        (irq_evt != 5'h00) |=> ((irq_stat_q & $past(irq_evt)) == $past(irq_evt)))
        else $error("Interrupt event not latched");

endmodule // usb_sie_ctrl_status_regs

`default_nettype wire

/* usb_host_evt_model.sv */
// Behavioural USB host side: produces serial engine events on the system clock
`timescale 1ns/10ps
`default_nettype none

module usb_host_evt_model (
    input wire logic clock_i,
    input wire logic nrst_i,
    output usb_sie_pkg::sie_evt_t evt_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // Event bit positions, low to high as the carrier struct packs them
    localparam int unsigned P_IN_TOK = 0;
    localparam int unsigned P_OUT_TOK = 1;
    localparam int unsigned P_EP0_ERR = 2;
    localparam int unsigned P_IN_DONE = 3;
    localparam int unsigned P_SETUP = 4;
    localparam int unsigned P_USB_RST = 5;

    logic [5:0] evt_q;

    // Quiet bus until the first token arrives
    initial evt_q = 6'h00;
    assign evt_o = usb_sie_pkg::sie_evt_t'(evt_q);

    // One-cycle event pulse; nothing is sent while the device sits in reset
    task automatic pulse(input int unsigned pos);
        wait (nrst_i === 1'b1);
        @(posedge clock_i);
        evt_q[pos] <= 1'b1;
        @(posedge clock_i);
        evt_q[pos] <= 1'b0;
        @(negedge clock_i);
    endtask

    // IN token in progress is a level, held by the host for the token's span
    task automatic set_in(input logic lvl);
        @(posedge clock_i);
        evt_q[P_IN_TOK] <= lvl;
        @(negedge clock_i);
    endtask
endmodule // usb_host_evt_model

`default_nettype wire

/* tb.sv */
// Self-checking bench for the USB engine control and status registers
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic clock_i = 1'b0;
    logic nrst_i;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [9:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    usb_sie_pkg::sie_evt_t evt;
    logic fifo_rd_req_i;
    logic fifo_wr_req_i;
    logic [2:0] fifo_selector_o;
    logic sel_valid_o;
    usb_sie_pkg::ep_kind_t sel_ep_kind_o;
    logic [4:0] fifo_rd_o;
    logic [4:0] fifo_wr_o;
    logic usb_clock_gate_o, deep_suspend_ctl_o, pll_clock_sel_o, crystal_freq_sel_o;
    logic remote_wake_allow_o;
    logic [6:0] dev_addr_o;
    logic [4:0] endpoint_halt_bits_o;
    logic irq_o;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [31:0] rdata;
    logic [4:0] onehot;
    usb_sie_pkg::ep_kind_t kinds [8];

    always #5 clock_i = ~clock_i;

    usb_sie_ctrl_status_regs #(.NUM_EP(5)) u_usb_sie_ctrl_status_regs (
        .clock_i(clock_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sie_evt_i(evt),
        .fifo_rd_req_i(fifo_rd_req_i), .fifo_wr_req_i(fifo_wr_req_i),
        .fifo_selector_o(fifo_selector_o), .sel_valid_o(sel_valid_o),
        .sel_ep_kind_o(sel_ep_kind_o), .fifo_rd_o(fifo_rd_o), .fifo_wr_o(fifo_wr_o),
        .usb_clock_gate_o(usb_clock_gate_o), .deep_suspend_ctl_o(deep_suspend_ctl_o),
        .pll_clock_sel_o(pll_clock_sel_o), .crystal_freq_sel_o(crystal_freq_sel_o),
        .remote_wake_allow_o(remote_wake_allow_o), .dev_addr_o(dev_addr_o),
        .endpoint_halt_bits_o(endpoint_halt_bits_o), .irq_o(irq_o)
    );

    usb_host_evt_model u_usb_host_evt_model (.clock_i(clock_i), .nrst_i(nrst_i), .evt_o(evt));

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run, shared by the main sequence and the watchdog
    task automatic tally_and_finish;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Classic single cycle: hold the request until ack is sampled high, then release
    task automatic wb_cycle(input logic [7:0] idx, input logic we, input logic [7:0] wd,
                            input logic [3:0] sel);
        @(posedge clock_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sel;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, wd};
        // No answer time assumed; only the watchdog ends a wait that never answers
        @(posedge clock_i);
        while (wb_ack_o !== 1'b1) begin
            @(posedge clock_i);
        end
        rdata = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        // Let the ack edge's register updates settle before outputs are compared
        @(negedge clock_i);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        wb_cycle(idx, 1'b1, d, 4'hF);
    endtask

    task automatic rd(input string name, input logic [7:0] idx, input logic [7:0] exp);
        wb_cycle(idx, 1'b0, 8'h00, 4'hF);
        check(name, rdata, {24'h000000, exp});
    endtask

    // Watchdog sized well above the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clock_i);
        n_mismatch++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        kinds = '{usb_sie_pkg::EP_CONTROL, usb_sie_pkg::EP_INTERRUPT, usb_sie_pkg::EP_ISO_OUT,
                  usb_sie_pkg::EP_ISO_IN, usb_sie_pkg::EP_INTERRUPT, usb_sie_pkg::EP_CONTROL,
                  usb_sie_pkg::EP_CONTROL, usb_sie_pkg::EP_CONTROL};
        nrst_i <= 1'b0;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        wb_adr_i <= 10'h000;
        wb_sel_i <= 4'hF;
        wb_dat_i <= 32'h00000000;
        fifo_rd_req_i <= 1'b0;
        fifo_wr_req_i <= 1'b0;
        repeat (16) @(posedge clock_i);
        nrst_i <= 1'b1;
        rd("clock reg reset", 8'h22, 8'h00);
        rd("addr reg reset", 8'h23, 8'h00);
        rd("halt reset", 8'h24, 8'h00);
        rd("status reset", 8'h25, 8'h00);
        rd("mask reset", 8'h31, 8'h00);
        check("addr out reset", 32'(dev_addr_o), 32'h00000000);
        // Each control bit alone, so a swapped output shows up
        for (int b = 3; b <= 6; b++) begin
            wr(8'h22, 8'(1 << b));
            check("clock outs", 32'({crystal_freq_sel_o, pll_clock_sel_o, deep_suspend_ctl_o,
                  usb_clock_gate_o}), 32'(1 << (b - 3)));
        end
        wr(8'h22, 8'hFF);
        rd("clock reg top bit", 8'h22, 8'h7F);
        // Every selector code, reserved ones included
        for (int c = 0; c < 8; c++) begin
            wr(8'h22, 8'(c));
            @(posedge clock_i);
            fifo_rd_req_i <= 1'b1;
            fifo_wr_req_i <= c[0];
            @(negedge clock_i);
            onehot = (c <= 4) ? 5'(1 << c) : 5'h00;
            check("selector", 32'(fifo_selector_o), 32'(c));
            check("sel valid", 32'(sel_valid_o), 32'(c <= 4));
            check("ep kind", 32'(sel_ep_kind_o), 32'(kinds[c]));
            check("fifo rd", 32'(fifo_rd_o), 32'(onehot));
            check("fifo wr", 32'(fifo_wr_o), c[0] ? 32'(onehot) : 32'h0);
        end
        // Address write adopted at once while deferral is off
        wr(8'h23, 8'hAB);
        check("wake", 32'(remote_wake_allow_o), 32'h1);
        check("addr now", 32'(dev_addr_o), 32'h55);
        // Deferred update waits for a completed IN read
        wr(8'h25, 8'h01);
        wr(8'h23, 8'h22);
        check("addr held", 32'(dev_addr_o), 32'h55);
        u_usb_host_evt_model.pulse(3);
        check("addr adopted", 32'(dev_addr_o), 32'h11);
        // A write with the low byte lane off is acked but must leave the register alone
        wb_cycle(8'h23, 1'b1, 8'hFE, 4'hE);
        rd("sel ignored", 8'h23, 8'h22);
        // Halt, OUT and error flags against a SETUP token
        wr(8'h24, 8'hFF);
        rd("halt bits", 8'h24, 8'h1F);
        u_usb_host_evt_model.pulse(1);
        rd("out flag", 8'h25, 8'h05);
        u_usb_host_evt_model.pulse(2);
        rd("err flag", 8'h25, 8'h07);
        u_usb_host_evt_model.pulse(4);
        rd("setup clears out", 8'h25, 8'h03);
        rd("setup clears halt", 8'h24, 8'h00);
        wr(8'h25, 8'h02);
        rd("defer cleared", 8'h25, 8'h02);
        wr(8'h25, 8'h00);
        rd("err cleared", 8'h25, 8'h00);
        wr(8'h24, 8'h1F);
        check("halt out", 32'(endpoint_halt_bits_o), 32'h1F);
        u_usb_host_evt_model.pulse(5);
        check("usb reset halt", 32'(endpoint_halt_bits_o), 32'h00);
        // IN indication is read-only
        u_usb_host_evt_model.set_in(1'b1);
        rd("in flag", 8'h25, 8'h08);
        wr(8'h25, 8'h00);
        rd("in read only", 8'h25, 8'h08);
        u_usb_host_evt_model.set_in(1'b0);
        rd("in gone", 8'h25, 8'h00);
        // Interrupt: clear, unmask one source, raise, clear, mask
        wr(8'h30, 8'h1F);
        rd("irq cleared", 8'h30, 8'h00);
        wr(8'h31, 8'h02);
        check("irq idle", 32'(irq_o), 32'h0);
        u_usb_host_evt_model.pulse(2);
        check("irq high", 32'(irq_o), 32'h1);
        rd("irq status", 8'h30, 8'h02);
        wr(8'h30, 8'h02);
        check("irq low", 32'(irq_o), 32'h0);
        wr(8'h31, 8'h00);
        u_usb_host_evt_model.pulse(2);
        check("irq masked", 32'(irq_o), 32'h0);
        rd("irq sticky", 8'h30, 8'h02);
        rd("unmapped", 8'h40, 8'h00);
        tally_and_finish();
    end
endmodule // tb

`default_nettype wire
